// ---- src/otp_cmd_pkg.sv ----
// package for the security-page / reset / parameter-header command block
// assumes a serial link in mode 0: bits in on rising, out on falling edge
package otp_cmd_pkg;
  localparam logic [7:0] OP_PROG_PAGE = 8'h42;
  localparam logic [7:0] OP_READ_PAGE = 8'h48;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_GO = 8'h99;
  localparam logic [7:0] OP_READ_PARAM = 8'h5a;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam int PAGE_COUNT = 4;
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] ADDR_HIGH_ZERO = 8'h00;
  localparam logic [7:0] PAGE_MAX = 8'h03;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] MAKER_CODE = 8'h5e; // arbitrary value
  localparam int PROG_TIME_NS = 700000;
  localparam int RST_TIME_NS = 30000;
  localparam int CLK_NS = 40;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYCLES = (RST_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_CNT_W = 6;
  localparam logic [5:0] OP_DONE = 6'h08;
  localparam logic [5:0] ADDR_DONE = 6'h20;
  localparam logic [5:0] DUMMY_DONE = 6'h28;

  // one frame decoded at the link side, handed to the core domain
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic hasData;
  } frame_t;

  // one byte written to a page, handed across
  typedef struct packed {
    logic [9:0] index;
    logic [7:0] data;
  } wr_byte_t;

  // fixed header contents for byte offsets 00h-17h
  function automatic logic [7:0] header_byte(input logic [7:0] a);
    case (a)
      8'h00: header_byte = 8'h53;
      8'h01: header_byte = 8'h46;
      8'h02: header_byte = 8'h44;
      8'h03: header_byte = 8'h50;
      8'h04: header_byte = 8'h00;
      8'h05: header_byte = 8'h01;
      8'h06: header_byte = 8'h01;
      8'h08: header_byte = 8'h00;
      8'h09: header_byte = 8'h00;
      8'h0a: header_byte = 8'h01;
      8'h0b: header_byte = 8'h09;
      8'h0c: header_byte = 8'h30;
      8'h0d: header_byte = 8'h00;
      8'h0e: header_byte = 8'h00;
      8'h10: header_byte = MAKER_CODE;
      8'h11: header_byte = 8'h00;
      8'h12: header_byte = 8'h01;
      8'h13: header_byte = 8'h03;
      8'h14: header_byte = 8'h60;
      8'h15: header_byte = 8'h00;
      8'h16: header_byte = 8'h00;
      default: header_byte = ERASED_BYTE;
    endcase
  endfunction
endpackage

// ---- src/otp_page_mem.sv ----
// four security pages as one memory, registered read, one write port
// assumes a single clock; read and write ports may work in the same cycle
`timescale 1ns/1ps
module otp_page_mem
  import otp_cmd_pkg::*;
#(
  parameter int DEPTH = PAGE_COUNT * PAGE_BYTES
) (
  input wire logic clk,
  input wire logic set_write_latch_cmd,
  input wire logic [9:0] wrIndex,
  input wire logic [7:0] wrData,
  input wire logic [9:0] rdIndex,
  output logic [7:0] rdData
);
  logic [7:0] mem [DEPTH];

  // =========================================================
  // storage: programming only clears bits, like a real cell
  always_ff @(posedge clk) begin
    if (set_write_latch_cmd) begin
      mem[wrIndex] <= mem[wrIndex] & wrData;
    end
    rdData <= mem[rdIndex];
  end

  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end
endmodule

// ---- src/otp_page_reset_sfdp_cmds.sv ----
// serial command block: security pages, software reset, parameter header
// assumes a host in mode 0 with CS low per frame; status bits live outside
// and arrive here as ports; the link logic runs on the host's serial clock
//
// Function
// - program acts only when the write enable latch is set
// - self-timed program starts when chip select rises after valid frame
// - write in progress reads one for whole program, zero after
// - write enable latch cleared before program cycle ends
// - lock bit set makes every program command ignored
// - address high byte zero, middle selects page 0-3, low is byte
// - read data shifts out on falling serial clock edge
// - read starts anywhere, address advances after each byte
// - low address byte wraps FFh to 00h within the same page
// - accepted reset aborts work, clears volatile state bits
// - commands refused during reset recovery time
// - opcode 5Ah reads the parameter space
// - header holds signature, revisions, count; unused bytes FFh
// - first header at 08h: ID 00h, rev 1.0, length 09h, ptr 30h
// - second header at 10h: maker code, rev 1.0, length 03h, ptr 60h
`timescale 1ns/1ps
module otp_page_reset_sfdp_cmds
  import otp_cmd_pkg::*;
#(
  parameter int PROG_CNT = PROG_CYCLES,
  parameter int RST_CNT = RST_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic serClk,
  input wire logic chipSelN,
  input wire logic serIn,
  output logic serOut,
  output logic serOutEn,
  input wire logic securityLockBit,
  input wire logic suspendFlagIn,
  output logic writeEnableLatch,
  output logic writeInProgress,
  output logic resetPulse,
  output logic busyRecover
);
  // =========================================================
  // link side: shift in on rising edge
  logic [BIT_CNT_W-1:0] bitCnt_ff;
  logic [7:0] opcode_ff;
  logic [23:0] addr_ff;
  logic [7:0] inByte_ff;
  logic hasData_ff;
  logic [7:0] shift_ff;
  logic [7:0] rdAddr_ff;
  logic progFrame;
  logic readFrame;
  logic [7:0] nxtIn;
  logic [9:0] wrIndex_ff;
  logic [7:0] wrData_ff;
  // toggles start known: their domains have no reset of their own
  logic wrToggle_ff = 1'b0;
  logic frmToggle_ff = 1'b0;
  logic wrPending;
  frame_t frame_ff;
  logic busyLink_m_ff;
  logic busyLink_ff;
  logic [7:0] memRd;
  logic [7:0] outByte;

  assign nxtIn = {inByte_ff[6:0], serIn};
  assign progFrame = opcode_ff == OP_PROG_PAGE;
  // both reads share fast-read framing
  assign readFrame = opcode_ff == OP_READ_PAGE
    || opcode_ff == OP_READ_PARAM;

  // core refusal state reaches the link through two flops
  always_ff @(posedge serClk) begin
    busyLink_m_ff <= busyRecover;
    busyLink_ff <= busyLink_m_ff;
  end

  // frame counter restarts while chip select is high; no edge needed then
  always_ff @(posedge serClk or posedge chipSelN) begin
    if (chipSelN) begin
      bitCnt_ff <= '0;
      inByte_ff <= '0;
    end else begin
      inByte_ff <= nxtIn;
      if (bitCnt_ff != DUMMY_DONE) begin
        bitCnt_ff <= bitCnt_ff + 6'h01;
      end else begin
        bitCnt_ff <= bitCnt_ff - 6'h07; // keep counting data bytes
      end
    end
  end

  // opcode, address and write data capture, bits latched on rise
  always_ff @(posedge serClk) begin
    if (bitCnt_ff == OP_DONE - 6'h01 && !chipSelN) begin
      opcode_ff <= busyLink_ff ? 8'h00 : nxtIn;
      hasData_ff <= 1'b0;
    end
    if (bitCnt_ff >= OP_DONE && bitCnt_ff < ADDR_DONE && !chipSelN) begin
      addr_ff <= {addr_ff[22:0], serIn};
    end
    if (bitCnt_ff[2:0] == 3'h7 && bitCnt_ff >= ADDR_DONE && !chipSelN
        && progFrame && addr_ff[23:16] == ADDR_HIGH_ZERO
        && addr_ff[15:8] <= PAGE_MAX) begin
      // first byte at the address, later bytes step within the page
      hasData_ff <= 1'b1;
      wrData_ff <= nxtIn;
      wrIndex_ff <= hasData_ff
        ? {wrIndex_ff[9:8], wrIndex_ff[7:0] + 8'h01}
        : addr_ff[9:0];
      wrToggle_ff <= ~wrToggle_ff;
    end
  end

  // end of frame reported on chip select rise
  always_ff @(posedge chipSelN) begin
    frame_ff <= '{opcode: opcode_ff, addr: addr_ff, hasData: hasData_ff};
    frmToggle_ff <= ~frmToggle_ff;
  end

  // output shifting on falling edge; load a byte each eighth bit
  always_ff @(negedge serClk or posedge chipSelN) begin
    if (chipSelN) begin
      serOutEn <= 1'b0;
      shift_ff <= '0;
      rdAddr_ff <= '0;
    end else if (readFrame && bitCnt_ff == DUMMY_DONE) begin
      // counter sits at the dummy end after every full byte
      serOutEn <= 1'b1;
      shift_ff <= outByte;
      rdAddr_ff <= (serOutEn ? rdAddr_ff : addr_ff[7:0])
        + 8'h01;
    end else begin
      shift_ff <= {shift_ff[6:0], 1'b0};
    end
  end
  assign serOut = shift_ff[7];

  // source of the next byte out: page memory, fixed header, or FFh off the pages
  always_comb begin
    if (opcode_ff == OP_READ_PARAM) begin
      outByte = header_byte(serOutEn ? rdAddr_ff : addr_ff[7:0]);
    end else if (addr_ff[23:16] != ADDR_HIGH_ZERO
                 || addr_ff[15:8] > PAGE_MAX) begin
      outByte = ERASED_BYTE;
    end else begin
      outByte = memRd;
    end
  end

  // page memory lives on the link clock so reads need no domain crossing
  otp_page_mem u_mem (
    .clk(serClk),
    .set_write_latch_cmd(wrPending),
    .wrIndex(wrIndex_ff),
    .wrData(wrData_ff),
    .rdIndex({addr_ff[9:8], serOutEn ? rdAddr_ff : addr_ff[7:0]}),
    .rdData(memRd)
  );

  // =========================================================
  // write gating: bytes commit only if a program will be honoured
  logic wrOk_m_ff;
  logic wrOk_ff;
  logic wrTogLast_ff = 1'b0;
  assign wrPending = (wrToggle_ff != wrTogLast_ff) && wrOk_ff;
  always_ff @(posedge serClk) begin
    wrOk_m_ff <= writeEnableLatch && !securityLockBit && !writeInProgress
      && !suspendFlagIn;
    wrOk_ff <= wrOk_m_ff;
    wrTogLast_ff <= wrToggle_ff;
  end

  // =========================================================
  // core side: frame decode, program timer, reset sequencing
  logic frmPulse;
  logic resetArmed_ff;
  logic [31:0] progCnt_ff;
  logic [31:0] rstCnt_ff;
  logic validProg;
  logic lockM_ff;
  logic lock_ff;
  logic susM_ff;
  logic sus_ff;

  // status pins come from another domain: two flops before use
  always_ff @(posedge ref_clk) begin
    lockM_ff <= securityLockBit;
    lock_ff <= lockM_ff;
    susM_ff <= suspendFlagIn;
    sus_ff <= susM_ff;
  end

  otp_sync_pulse u_frm (
    .dstClk(ref_clk),
    .srcToggle(frmToggle_ff),
    .pulse(frmPulse)
  );

  assign validProg = frame_ff.opcode == OP_PROG_PAGE && frame_ff.hasData
    && frame_ff.addr[23:16] == ADDR_HIGH_ZERO
    && frame_ff.addr[15:8] <= PAGE_MAX;

  // reset arming: 66h must be the frame just before 99h
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      resetArmed_ff <= 1'b0;
      resetPulse <= 1'b0;
    end else begin
      resetPulse <= 1'b0;
      if (frmPulse && !busyRecover) begin
        resetArmed_ff <= frame_ff.opcode == OP_RESET_ARM;
        if (resetArmed_ff && frame_ff.opcode == OP_RESET_GO) begin
          resetPulse <= 1'b1;
        end
      end
    end
  end

  // recovery window after a reset refuses commands
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rstCnt_ff <= '0;
      busyRecover <= 1'b0;
    end else if (resetPulse) begin
      rstCnt_ff <= 32'(RST_CNT);
      busyRecover <= 1'b1;
    end else if (rstCnt_ff != '0) begin
      rstCnt_ff <= rstCnt_ff - 32'h1;
      busyRecover <= rstCnt_ff != 32'h1;
    end
  end

  // write latch: set by 06h, cleared one cycle before program end or by reset
  always_ff @(posedge ref_clk) begin
    if (srst || resetPulse) begin
      writeEnableLatch <= 1'b0;
    end else if (frmPulse && !busyRecover
                 && frame_ff.opcode == OP_SET_LATCH) begin
      writeEnableLatch <= 1'b1;
    end else if (writeInProgress && progCnt_ff == 32'h2) begin
      writeEnableLatch <= 1'b0;
    end
  end

  // self-timed program cycle started at chip select rise
  always_ff @(posedge ref_clk) begin
    if (srst || resetPulse) begin
      progCnt_ff <= '0;
      writeInProgress <= 1'b0;
    end else if (frmPulse && validProg && writeEnableLatch
                 && !lock_ff && !busyRecover
                 && !writeInProgress && !sus_ff) begin
      progCnt_ff <= 32'(PROG_CNT);
      writeInProgress <= 1'b1;
    end else if (progCnt_ff != '0) begin
      progCnt_ff <= progCnt_ff - 32'h1;
      writeInProgress <= progCnt_ff != 32'h1;
    end
  end
endmodule

// ---- src/otp_sync_pulse.sv ----
// toggle-based event crossing with two-flop synchroniser
// assumes source events are spaced wider than three destination cycles
`timescale 1ns/1ps
module otp_sync_pulse (
  input wire logic dstClk,
  input wire logic srcToggle,
  output logic pulse
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // =========================================================
  // first flop read only by second; edge detect after
  always_ff @(posedge dstClk) begin
    meta_ff <= srcToggle;
    sync_ff <= meta_ff;
    last_ff <= sync_ff;
  end

  assign pulse = sync_ff ^ last_ff;
endmodule

// ---- test/otp_cmd_checker.sv ----
// port assertions for the security-page command block
// assumes core-side outputs are registered on ref_clk
`timescale 1ns/1ps
module otp_cmd_checker #(
  parameter int PROG_CNT = 20,
  parameter int RST_CNT = 10
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic serClk,
  input wire logic chipSelN,
  input wire logic securityLockBit,
  input wire logic serOutEn,
  input wire logic writeEnableLatch,
  input wire logic writeInProgress,
  input wire logic resetPulse,
  input wire logic busyRecover
);
  // ====
  // run lengths of the two timed states
  int progCnt_ff;
  int recCnt_ff;
  always_ff @(posedge ref_clk) begin
    progCnt_ff <= (srst || !writeInProgress) ? 0 : progCnt_ff + 1;
  end
  always_ff @(posedge ref_clk) begin
    recCnt_ff <= (srst || !busyRecover) ? 0 : recCnt_ff + 1;
  end
  // ====
  // program, lock and reset relations
  a_prog_needs_latch: assert property (@(posedge ref_clk)
    disable iff (srst) $rose(writeInProgress) |->
    ($past(writeEnableLatch) || $past(writeEnableLatch, 2)))
    else $error("program began without latch");
  a_lock_blocks: assert property (@(posedge ref_clk)
    disable iff (srst) $rose(writeInProgress) |-> !securityLockBit)
    else $error("program began while locked");
  a_latch_gone: assert property (@(posedge ref_clk)
    disable iff (srst) $fell(writeInProgress) |-> !writeEnableLatch)
    else $error("latch still set after program");
  a_prog_bound: assert property (@(posedge ref_clk)
    disable iff (srst) writeInProgress |-> progCnt_ff < PROG_CNT)
    else $error("program cycle too long");
  a_pulse_single: assert property (@(posedge ref_clk)
    disable iff (srst) resetPulse |=> !resetPulse)
    else $error("reset pulse too wide");
  a_reset_clears: assert property (@(posedge ref_clk)
    disable iff (srst) resetPulse |-> ##[0:2] (busyRecover &&
    !writeEnableLatch && !writeInProgress))
    else $error("reset left state behind");
  a_recover_bound: assert property (@(posedge ref_clk)
    disable iff (srst) busyRecover |-> recCnt_ff < RST_CNT)
    else $error("recovery too long");
  a_recover_quiet: assert property (@(posedge ref_clk)
    disable iff (srst) $rose(writeInProgress) |-> !$past(busyRecover))
    else $error("program began in recovery");
  a_out_in_frame: assert property (@(negedge serClk)
    disable iff (srst) serOutEn |-> !chipSelN)
    else $error("output driven outside frame");
  c_prog: cover property (@(posedge ref_clk) $fell(writeInProgress));
  c_reset: cover property (@(posedge ref_clk) resetPulse);
  c_read: cover property (@(negedge serClk) serOutEn);
endmodule
bind otp_page_reset_sfdp_cmds otp_cmd_checker #(.PROG_CNT(PROG_CNT),
  .RST_CNT(RST_CNT)) u_chk (.ref_clk(ref_clk), .srst(srst),
  .serClk(serClk), .chipSelN(chipSelN), .serOutEn(serOutEn),
  .securityLockBit(securityLockBit), .resetPulse(resetPulse),
  .writeEnableLatch(writeEnableLatch), .busyRecover(busyRecover),
  .writeInProgress(writeInProgress));

// ---- test/otp_host_model.sv ----
// serial host model: mode 0 frames, 125 ns link clock
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module otp_host_model (
  output logic serClk,
  output logic chipSelN,
  output logic serIn,
  input wire logic serOut
);
  // ====
  // idle link: deselected, clock stands low
  initial begin
    serClk = 1'b0;
    chipSelN = 1'b1;
    serIn = 1'b0;
  end
  // a frame opens with select low
  task automatic start();
    chipSelN = 1'b0;
    #62.5;
  endtask
  // one byte msb first; reply bits settle on the fall before each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serIn = tx[i];
      #62.5 serClk = 1'b1;
      rx[i] = serOut;
      #62.5 serClk = 1'b0;
    end
    serIn = ~tx[0]; // a released line must not look valid
  endtask
  // gap keeps frames wider than the crossing needs
  task automatic stop();
    #62.5 chipSelN = 1'b1;
    #400;
  endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the security-page command block
// assumes the host model and the bound checker
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; \
  if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb_top;
  import otp_cmd_pkg::*;
  localparam int PCNT = 200;
  localparam int RCNT = 60;
  logic ref_clk, srst, securityLockBit, suspendFlagIn;
  logic serClk, chipSelN, serIn, serOut, serOutEn;
  logic writeEnableLatch, writeInProgress, resetPulse, busyRecover;
  int errors = 0, cmp_count = 0, pulses = 0, progLen = 0, lastLen = 0;
  logic [7:0] rx;
  logic [7:0] hdr [24];
  otp_page_reset_sfdp_cmds #(.PROG_CNT(PCNT), .RST_CNT(RCNT)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .serClk(serClk),
    .chipSelN(chipSelN), .serIn(serIn), .serOut(serOut),
    .serOutEn(serOutEn), .securityLockBit(securityLockBit),
    .suspendFlagIn(suspendFlagIn), .writeEnableLatch(writeEnableLatch),
    .writeInProgress(writeInProgress), .resetPulse(resetPulse),
    .busyRecover(busyRecover));
  otp_host_model i_host (.serClk(serClk), .chipSelN(chipSelN),
    .serIn(serIn), .serOut(serOut));
  // ====
  // core clock and run-length monitors
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (resetPulse === 1'b1) pulses++;
    if (writeInProgress === 1'b1) progLen++;
    else if (progLen != 0) begin
      lastLen = progLen;
      progLen = 0;
    end
  end
  // ====
  // access tasks
  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    i_host.start();
    i_host.xfer(op, rx);
    i_host.stop();
  endtask
  // opcode and address, select left low
  task automatic opa(input logic [7:0] op, input logic [23:0] a);
    i_host.start();
    i_host.xfer(op, rx);
    for (int i = 2; i >= 0; i--) i_host.xfer(a[i*8 +: 8], rx);
  endtask
  task automatic prog(input logic [23:0] a, input logic [7:0] d);
    opa(OP_PROG_PAGE, a);
    i_host.xfer(d, rx);
    i_host.stop();
  endtask
  // read opcode, address and dummy byte
  task automatic rd(input logic [7:0] op, input logic [23:0] a);
    opa(op, a);
    i_host.xfer(8'hff, rx);
  endtask
  // bounded wait on the busy flag
  task automatic wait_prog(input logic lvl);
    int n;
    n = 0;
    while (writeInProgress !== lvl) begin
      @(posedge ref_clk);
      n++;
      if (n > 2000) begin
        `CHK(1'b0, 1'b1, "wait timeout")
        print_verdict();
      end
    end
    #1;
  endtask
  // ====
  // scenarios
  initial begin
    srst = 1'b1;
    securityLockBit = 1'b0;
    suspendFlagIn = 1'b0;
    hdr = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
      8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
      MAKER_CODE, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hff};
    repeat (8) @(posedge ref_clk);
    #1 srst = 1'b0;
    `CHK({writeEnableLatch, writeInProgress}, 2'b00, "reset")
    prog(24'h0002ff, 8'ha5);
    `CHK(writeInProgress, 1'b0, "program without latch")
    cmd(OP_SET_LATCH);
    `CHK(writeEnableLatch, 1'b1, "latch set")
    prog(24'h0002ff, 8'ha5);
    wait_prog(1'b1);
    wait_prog(1'b0);
    `CHK(lastLen, PCNT, "program length")
    `CHK(writeEnableLatch, 1'b0, "latch after program")
    cmd(OP_SET_LATCH);
    prog(24'h000200, 8'h3c);
    wait_prog(1'b0);
    rd(OP_READ_PAGE, 24'h0002ff);
    i_host.xfer(8'hff, rx);
    `CHK(rx, 8'ha5, "page byte ff")
    `CHK(serOutEn, 1'b1, "output driven")
    i_host.xfer(8'hff, rx);
    `CHK(rx, 8'h3c, "page wrap")
    i_host.stop();
    `CHK(serOutEn, 1'b0, "output released")
    cmd(OP_SET_LATCH);
    @(posedge ref_clk);
    #1 securityLockBit = 1'b1;
    prog(24'h000100, 8'h00);
    `CHK(writeInProgress, 1'b0, "locked program")
    @(posedge ref_clk);
    #1 securityLockBit = 1'b0;
    suspendFlagIn = 1'b1;
    prog(24'h000300, 8'h11);
    `CHK(writeInProgress, 1'b0, "suspended program")
    @(posedge ref_clk);
    #1 suspendFlagIn = 1'b0;
    prog(24'h000300, 8'h11);
    wait_prog(1'b1);
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_GO);
    `CHK(pulses, 1, "reset accepted")
    `CHK({writeEnableLatch, writeInProgress}, 2'b00, "abort")
    `CHK(busyRecover, 1'b1, "recovering")
    cmd(OP_SET_LATCH);
    `CHK(writeEnableLatch, 1'b0, "refused in recovery")
    repeat (RCNT) @(posedge ref_clk);
    #1 cmd(OP_SET_LATCH);
    `CHK(writeEnableLatch, 1'b1, "latch after recovery")
    `CHK(writeInProgress, 1'b0, "idle before reset")
    cmd(OP_RESET_ARM);
    cmd(OP_SET_LATCH);
    cmd(OP_RESET_GO);
    `CHK(pulses, 1, "split reset ignored")
    rd(OP_READ_PARAM, 24'h000000);
    for (int i = 0; i < 24; i++) begin
      i_host.xfer(8'hff, rx);
      `CHK(rx, hdr[i], "header byte")
    end
    i_host.stop();
    print_verdict();
  end
endmodule
